// [src/adc_seq_pkg.sv]
// Constants shared by the converter sequence control block
package adc_seq_pkg;
    // Register byte offsets
    localparam logic [3:0] ctl2_off = 4'h0;
    localparam logic [3:0] clk_off  = 4'h4;
    localparam logic [3:0] chs_off  = 4'h8;
    localparam logic [3:0] ists_off = 4'hc;
    // Interrupt block offsets (status read-only, clear write-only, enable)
    localparam logic [4:0] irq_sts_off = 5'h10;
    localparam logic [4:0] irq_clr_off = 5'h14;
    localparam logic [4:0] irq_en_off  = 5'h18;
    // Second control register fields
    localparam int ref_lsb      = 13;
    localparam int reserved_pos = 12;
    localparam int scan_pos     = 10;
    localparam int fill_pos     = 7;
    localparam int rate_lsb     = 2;
    localparam int split_pos    = 1;
    localparam int alt_pos      = 0;
    localparam logic [15:0] ctl2_wmask = 16'he43f;
    // Clock timing fields
    localparam int src_pos     = 15;
    localparam int samp_lsb    = 8;
    localparam int div_lsb     = 0;
    localparam logic [15:0] clk_wmask = 16'h9fff;
    // Channel select fields
    localparam int negb_pos = 15;
    localparam int posb_lsb = 8;
    localparam int nega_pos = 7;
    localparam int posa_lsb = 0;
    localparam logic [15:0] chs_wmask = 16'h9f9f;
    // Reset values
    localparam logic [15:0] ctl2_rst = 16'h0000;
    localparam logic [15:0] clk_rst  = 16'h0000;
    localparam logic [15:0] chs_rst  = 16'h0000;
    // Reference codes
    localparam logic [2:0] ref_sup   = 3'h0;
    localparam logic [2:0] ref_extp  = 3'h1;
    localparam logic [2:0] ref_extn  = 3'h2;
    localparam logic [2:0] ref_both  = 3'h3;
    // Conversion length in conversion clock periods
    localparam logic [3:0] conv_periods = 4'hc;
    // Interrupt status bits
    localparam int ev_seq  = 0;
    localparam int ev_half = 1;
endpackage

// [src/adc_tick_div.sv]
// Conversion clock tick generator with clock source selection
`timescale 1ns/10ps
`default_nettype none
module adc_tick_div
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Control
    input  wire logic       src_rc,
    input  wire logic [7:0] divider,
    input  wire logic       rc_clk_in,
    // Tick
    output logic            tick
);
    logic [7:0] cnt_r;
    logic [2:0] rc_sync_r;
    wire        rc_edge = rc_sync_r[1] & ~rc_sync_r[2];
    wire        div_hit = (cnt_r >= divider);

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            rc_sync_r <= 3'h0;
        else
            rc_sync_r <= {rc_sync_r[1:0], rc_clk_in};

    // Period is divider plus one system cycles
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            cnt_r <= 8'h00;
        else if (src_rc | div_hit)
            cnt_r <= 8'h00;
        else
            cnt_r <= cnt_r + 8'h01;

    // RC source uses synchronised edges of the internal oscillator
    assign tick = src_rc ? rc_edge : div_hit;
endmodule
`default_nettype wire

// [src/adc_sequence_control.sv]
// Sequence control for a successive-approximation converter
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Reference code picks supply/ground, external plus, external minus or both; 1xx supply.
// - Scan enable steps the first positive input through the scan list; else fixed.
// - In split mode the fill flag shows which half is being written.
// - Interrupt after every rate-plus-one completed sequences.
// - Split mode uses two eight-word halves, else one sixteen-word buffer.
// - Alternate mode uses A first, then B and A in turn.
// - Clock source bit picks the internal RC clock or the divided system clock.
// - Auto-sample field gives 0 to 31 conversion clock periods of sampling.
// - Divider field gives a period of field plus one system cycles.
module adc_sequence_control
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Sequencing
    input  wire logic        start,
    input  wire logic [17:0] scan_list,
    input  wire logic        rc_clk_in,
    // Analog front end control
    output logic             sample_hold,
    output logic             convert,
    output logic             pos_ref_ext,
    output logic             neg_ref_ext,
    output logic [4:0]       pos_input,
    output logic             neg_input_ref,
    output logic [3:0]       result_addr,
    output logic             result_we,
    output logic             busy,
    // Interrupt
    output logic             irq
);
    //////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0]
    {
        st_idle = 3'b001,
        st_samp = 3'b010,
        st_conv = 3'b100
    } seq_state_t;

    logic [15:0] ctl2_r;
    logic [15:0] clk_r;
    logic [15:0] chs_r;
    logic [1:0]  irq_sts_r;
    logic [1:0]  irq_en_r;
    logic        ack_r;
    logic [31:0] rdata_r;
    seq_state_t  state_r;
    seq_state_t  state_nxt;
    logic [4:0]  tcnt_r;
    logic [3:0]  wptr_r;
    logic [3:0]  seq_cnt_r;
    logic        use_b_r;
    logic [4:0]  scan_idx_r;
    logic [1:0]  start_sync_r;
    logic        start_d_r;
    logic        tick;

    //////////////////////////////////////////////////////////////////////////
    // Field decode
    wire [2:0] reference_select   = ctl2_r[adc_seq_pkg::ref_lsb +: 3];
    wire       scan_enable        = ctl2_r[adc_seq_pkg::scan_pos];
    wire [3:0] interrupt_rate     = ctl2_r[adc_seq_pkg::rate_lsb +: 4];
    wire       buffer_split_mode  = ctl2_r[adc_seq_pkg::split_pos];
    wire       alternate_sample   = ctl2_r[adc_seq_pkg::alt_pos];
    wire       clock_source_select = clk_r[adc_seq_pkg::src_pos];
    wire [4:0] auto_sample_time   = clk_r[adc_seq_pkg::samp_lsb +: 5];
    wire [7:0] clock_divider      = clk_r[adc_seq_pkg::div_lsb +: 8];
    wire       neg_input_sel_b    = chs_r[adc_seq_pkg::negb_pos];
    wire [4:0] pos_input_sel_b    = chs_r[adc_seq_pkg::posb_lsb +: 5];
    wire       neg_input_sel_a    = chs_r[adc_seq_pkg::nega_pos];
    wire [4:0] pos_input_sel_a    = chs_r[adc_seq_pkg::posa_lsb +: 5];
    // Fill flag is live only in split mode; the top write pointer bit marks the half
    wire       buffer_fill_status = buffer_split_mode & wptr_r[3];

    //////////////////////////////////////////////////////////////////////////
    // Register bus: one wait cycle on every access so read data stays registered
    wire access   = avs_read | avs_write;
    wire wr_go    = avs_write & ack_r;
    wire sel_ctl2 = avs_address == {1'b0, adc_seq_pkg::ctl2_off};
    wire sel_clk  = avs_address == {1'b0, adc_seq_pkg::clk_off};
    wire sel_chs  = avs_address == {1'b0, adc_seq_pkg::chs_off};
    wire sel_ists = avs_address == adc_seq_pkg::irq_sts_off;
    wire sel_iclr = avs_address == adc_seq_pkg::irq_clr_off;
    wire sel_ien  = avs_address == adc_seq_pkg::irq_en_off;
    wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [15:0] wd = avs_writedata[15:0];

    // Reserved bit 12 is not writable, so a careless write cannot set it
    wire [15:0] ctl2_wm = adc_seq_pkg::ctl2_wmask & be_mask;
    wire [15:0] clk_wm  = adc_seq_pkg::clk_wmask & be_mask;
    wire [15:0] chs_wm  = adc_seq_pkg::chs_wmask & be_mask;
    wire [15:0] ctl2_rd = {ctl2_r[15:8], buffer_fill_status, ctl2_r[6:0]};
    wire [31:0] rd_mux = sel_ctl2 ? {16'h0000, ctl2_rd} :
                         sel_clk  ? {16'h0000, clk_r} :
                         sel_chs  ? {16'h0000, chs_r} :
                         sel_ists ? {30'h0000_0000, irq_sts_r} :
                         sel_ien  ? {30'h0000_0000, irq_en_r} : 32'h0000_0000;

    assign avs_waitrequest = access & ~ack_r;
    assign avs_readdata    = rdata_r;

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= access & ~ack_r;

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            rdata_r <= 32'h0000_0000;
        else if (avs_read & ~ack_r)
            rdata_r <= rd_mux;

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            ctl2_r <= adc_seq_pkg::ctl2_rst;
            clk_r  <= adc_seq_pkg::clk_rst;
            chs_r  <= adc_seq_pkg::chs_rst;
        end
        else if (wr_go)
        begin
            if (sel_ctl2)
                ctl2_r <= (ctl2_r & ~ctl2_wm) | (wd & ctl2_wm);
            if (sel_clk)
                clk_r <= (clk_r & ~clk_wm) | (wd & clk_wm);
            if (sel_chs)
                chs_r <= (chs_r & ~chs_wm) | (wd & chs_wm);
        end

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            irq_en_r <= 2'h0;
        else if (wr_go & sel_ien & avs_byteenable[0])
            irq_en_r <= avs_writedata[1:0];

    //////////////////////////////////////////////////////////////////////////
    // Conversion clock
    adc_tick_div u_tick
    (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .src_rc    (clock_source_select),
        .divider   (clock_divider),
        .rc_clk_in (rc_clk_in),
        .tick      (tick)
    );

    // Start is an external trigger, so it is synchronised and edge detected
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            start_sync_r <= 2'h0;
            start_d_r    <= 1'b0;
        end
        else
        begin
            start_sync_r <= {start_sync_r[0], start};
            start_d_r    <= start_sync_r[1];
        end
    wire start_pulse = start_sync_r[1] & ~start_d_r;

    //////////////////////////////////////////////////////////////////////////
    // Sequencer
    wire samp_done = tick & (tcnt_r >= auto_sample_time);
    wire conv_done = tick & (tcnt_r == {1'b0, adc_seq_pkg::conv_periods - 4'h1});
    wire seq_end   = (state_r == st_conv) & conv_done;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            st_idle: if (start_pulse) state_nxt = (auto_sample_time == 5'h00) ? st_conv : st_samp;
            st_samp: if (samp_done)   state_nxt = st_conv;
            st_conv: if (conv_done)   state_nxt = st_idle;
            default: state_nxt = st_idle;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            state_r <= st_idle;
        else
            state_r <= state_nxt;

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            tcnt_r <= 5'h00;
        else if (state_nxt != state_r)
            tcnt_r <= 5'h00;
        else if (tick & (state_r != st_idle))
            tcnt_r <= tcnt_r + 5'h01;

    // Outside split mode the write pointer restarts at 0 at each interrupt; in split mode it wraps within its eight-word half and changes half only at an interrupt
    wire [3:0] wptr_inc = wptr_r + 4'h1;
    wire       irq_hit  = seq_end & (seq_cnt_r == interrupt_rate);
    // At each interrupt in split mode the filler jumps to the other half
    wire [3:0] wptr_adv = (buffer_split_mode & irq_hit) ? {~wptr_r[3], 3'h0} :
                          buffer_split_mode ? {wptr_r[3], wptr_inc[2:0]} :
                          (irq_hit ? 4'h0 : wptr_inc);

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            wptr_r    <= 4'h0;
            seq_cnt_r <= 4'h0;
        end
        else if (seq_end)
        begin
            wptr_r    <= wptr_adv;
            seq_cnt_r <= irq_hit ? 4'h0 : seq_cnt_r + 4'h1;
        end

    // Alternation: first sample uses A, then B and A by turns
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            use_b_r <= 1'b0;
        else if (~alternate_sample)
            use_b_r <= 1'b0;
        else if (seq_end)
            use_b_r <= ~use_b_r;

    // Scan index is where the search starts; the input used is the first enabled
    // entry at or after it, so an input missing from the list is sampled only when the list is empty
    logic [4:0] scan_cur;
    always_comb
    begin
        scan_cur = scan_idx_r;
        for (int k = 17; k >= 0; k--)
        begin
            if (scan_list[(32'(scan_idx_r) + k) % 18])
                scan_cur = 5'((32'(scan_idx_r) + k) % 18);
        end
    end
    wire [4:0] scan_last = 5'($bits(scan_list) - 1);
    wire [4:0] scan_step = (scan_cur == scan_last) ? 5'h00 : scan_cur + 5'h01;

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            scan_idx_r <= 5'h00;
        else if (~scan_enable)
            scan_idx_r <= 5'h00;
        else if (seq_end & ~use_b_r)
            scan_idx_r <= scan_step;

    //////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over a clear in the same cycle
    wire [1:0] ev_set = {irq_hit & buffer_split_mode, irq_hit};
    wire [1:0] ev_clr = (wr_go & sel_iclr & avs_byteenable[0]) ? avs_writedata[1:0] : 2'h0;

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            irq_sts_r <= 2'h0;
        else
            irq_sts_r <= (irq_sts_r & ~ev_clr) | ev_set;

    assign irq = |(irq_sts_r & irq_en_r);

    //////////////////////////////////////////////////////////////////////////
    // Front end outputs
    // Codes 1xx fall back to supply and ground
    wire ref_low = ~reference_select[2];
    wire [4:0] pos_a = scan_enable ? scan_cur : pos_input_sel_a;

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            pos_ref_ext   <= 1'b0;
            neg_ref_ext   <= 1'b0;
            pos_input     <= 5'h00;
            neg_input_ref <= 1'b0;
            sample_hold   <= 1'b0;
            convert       <= 1'b0;
            result_addr   <= 4'h0;
            result_we     <= 1'b0;
            busy          <= 1'b0;
        end
        else
        begin
            pos_ref_ext   <= ref_low & reference_select[0];
            neg_ref_ext   <= ref_low & reference_select[1];
            pos_input     <= use_b_r ? pos_input_sel_b : pos_a;
            neg_input_ref <= use_b_r ? neg_input_sel_b : neg_input_sel_a;
            sample_hold   <= state_nxt == st_samp;
            convert       <= state_nxt == st_conv;
            result_addr   <= wptr_r;
            result_we     <= seq_end;
            busy          <= state_nxt != st_idle;
        end
endmodule
`default_nettype wire

// [testbench/adc_sequence_control_checker.sv]
// Concurrent checks on the ports of the converter sequence control block
`timescale 1ns/10ps
`default_nettype none
module adc_sequence_control_checker
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Register bus
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Sequencing and front end
    input wire logic        start,
    input wire logic [17:0] scan_list,
    input wire logic        rc_clk_in,
    input wire logic        sample_hold,
    input wire logic        convert,
    input wire logic        pos_ref_ext,
    input wire logic        neg_ref_ext,
    input wire logic [4:0]  pos_input,
    input wire logic        neg_input_ref,
    input wire logic [3:0]  result_addr,
    input wire logic        result_we,
    input wire logic        busy,
    input wire logic        irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    //////////////////////////////////////////////////////////////////////////
    logic [15:0] ctl_r;
    logic [15:0] chs_r;
    logic [1:0]  since_r;
    wire logic       wr_ok    = avs_write && !avs_waitrequest && avs_byteenable[1:0] == 2'b11;
    wire logic       rd_ok    = avs_read && !avs_waitrequest;
    wire logic       at_ctl   = avs_address == {1'b0, adc_seq_pkg::ctl2_off};
    wire logic       at_chs   = avs_address == {1'b0, adc_seq_pkg::chs_off};
    wire logic [2:0] ref_code = ctl_r[15:13];
    // Mirrors of the settings, since only the bus is visible here
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctl_r   <= 16'h0000;
            chs_r   <= 16'h0000;
            since_r <= 2'h0;
        end
        else
        begin
            if (wr_ok && at_ctl)
                ctl_r <= avs_writedata[15:0];
            if (wr_ok && at_chs)
                chs_r <= avs_writedata[15:0];
            since_r <= avs_write ? 2'h0 : (since_r == 2'h3 ? since_r : since_r + 2'h1);
        end
    end
    //////////////////////////////////////////////////////////////////////////
    sequence s_ctl_read;
        rd_ok && at_ctl;
    endsequence
    sequence s_irq_off;
        wr_ok && avs_address == adc_seq_pkg::irq_en_off && avs_writedata[1:0] == 2'b00;
    endsequence
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("waitrequest low in first access cycle");
    a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access held more than one wait cycle");
    a_ref_decode: assert property (since_r == 2'h3 |-> pos_ref_ext == (ref_code == 3'h1 || ref_code == 3'h3)
        && neg_ref_ext == (ref_code == 3'h2 || ref_code == 3'h3)) else $error("reference select mismatch");
    a_reserved_zero: assert property (s_ctl_read |-> !avs_readdata[12])
        else $error("reserved control bit read as one");
    a_fill_single: assert property (s_ctl_read ##0 !ctl_r[1] |-> !avs_readdata[7])
        else $error("fill flag set outside split mode");
    a_mux_fixed: assert property (sample_hold && since_r == 2'h3 && !ctl_r[0] && !ctl_r[10]
        |-> pos_input == chs_r[4:0] && neg_input_ref == chs_r[7]) else $error("fixed input selection wrong");
    a_we_pulse: assert property (result_we |=> !result_we)
        else $error("result write longer than one cycle");
    a_busy_match: assert property (busy == (sample_hold || convert))
        else $error("busy differs from sample or convert phase");
    a_irq_masked: assert property (s_irq_off |=> !irq)
        else $error("interrupt high with all enables clear");
endmodule
bind adc_sequence_control adc_sequence_control_checker chk_i
(
    .ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .start, .scan_list, .rc_clk_in, .sample_hold, .convert,
    .pos_ref_ext, .neg_ref_ext, .pos_input, .neg_input_ref, .result_addr, .result_we, .busy, .irq
);
`default_nettype wire

// [testbench/adc_sequence_control_tb.sv]
// Self-checking bench for the converter sequence control block
`timescale 1ns/10ps
`default_nettype none
module adc_sequence_control_tb;
    localparam logic [4:0] a_ctl = {1'b0, adc_seq_pkg::ctl2_off};
    localparam logic [4:0] a_clk = {1'b0, adc_seq_pkg::clk_off};
    localparam logic [4:0] a_chs = {1'b0, adc_seq_pkg::chs_off};
    logic        ref_clk;
    logic        rst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        start;
    logic [17:0] scan_list;
    logic        rc_clk_in;
    logic        rc_on;
    logic [1:0]  rc_ph;
    logic [4:0]  pos_input;
    logic [3:0]  result_addr;
    logic        sample_hold, convert, pos_ref_ext, neg_ref_ext, neg_input_ref, result_we, busy, irq;
    int          bad_count;
    int          n_checks;
    int          ns_m;
    int          nc_m;
    logic [4:0]  pin_m;
    logic        neg_m;
    logic [3:0]  ra_m;
    logic [4:0]  reg_a [3] = '{a_ctl, a_clk, a_chs};
    logic [15:0] rst_t [3] = '{adc_seq_pkg::ctl2_rst, adc_seq_pkg::clk_rst, adc_seq_pkg::chs_rst};
    logic [15:0] mk_t [3]  = '{adc_seq_pkg::ctl2_wmask, adc_seq_pkg::clk_wmask, adc_seq_pkg::chs_wmask};
    int          sp_t [3]  = '{0, 31, 1};
    int          dv_t [3]  = '{0, 1, 255};
    int          rate_t [2] = '{15, 2};
    adc_sequence_control DUT
    (
        .ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .start, .scan_list, .rc_clk_in, .sample_hold, .convert,
        .pos_ref_ext, .neg_ref_ext, .pos_input, .neg_input_ref, .result_addr, .result_we, .busy, .irq
    );
    always #10 ref_clk = ~ref_clk;
    // RC clock of six system cycles a period; stands still outside its one test run
    always @(posedge ref_clk)
        if (rc_on)
        begin
            rc_ph     <= (rc_ph == 2'h2) ? 2'h0 : rc_ph + 2'h1;
            rc_clk_in <= (rc_ph == 2'h2) ? ~rc_clk_in : rc_clk_in;
        end
    //////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    // Tick phase against the start edge is free, so allow one tick of slack
    task automatic chk_in(input string nm, input int e, input int tol, input int g);
        n_checks++;
        if (g < e - tol || g > e + tol)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] wd, output logic [15:0] rd);
        int t;
        t = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, wd};
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge ref_clk);
            t++;
        end
        while (avs_waitrequest !== 1'b0 && t < 50);
        rd = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (t >= 50)
            bad_count++;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd_chk(input string nm, input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] d;
        bus(1'b0, a, 16'h0000, d);
        chk(nm, e, d & m);
    endtask
    task automatic run_seq;
        int   t;
        logic got;
        t = 0;
        got = 1'b0;
        ns_m = 0;
        nc_m = 0;
        @(posedge ref_clk);
        start <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            start <= 1'b0;
            t++;
            ns_m += int'(sample_hold === 1'b1);
            nc_m += int'(convert === 1'b1);
            if (sample_hold === 1'b1 && !got)
            begin
                got = 1'b1;
                pin_m = pos_input;
                neg_m = neg_input_ref;
            end
            ra_m = result_addr;
        end
        while (result_we !== 1'b1 && t < 20000);
        if (t >= 20000)
            bad_count++;
        repeat (3) @(posedge ref_clk);
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial
    begin
        #1_500_000;
        bad_count++;
        tally_and_finish;
    end
    initial
    begin
        logic [4:0] v [3];
        ref_clk = 1'b0;
        rst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata, start, scan_list, rc_clk_in, rc_on, rc_ph} = '0;
        avs_byteenable = 4'b0011;
        bad_count = 0;
        n_checks = 0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            rd_chk("reset value", reg_a[i], 16'hffff, rst_t[i]);
            wr(reg_a[i], 16'hffff);
            rd_chk("writable bits", reg_a[i], 16'hffff, mk_t[i]);
            wr(reg_a[i], 16'h0000);
        end
        wr(5'h1c, 16'hffff);
        rd_chk("unmapped read", 5'h1c, 16'hffff, 16'h0000);
        for (int c = 0; c < 8; c++)
        begin
            wr(a_ctl, {3'(c), 13'h0000});
            repeat (3) @(posedge ref_clk);
            chk1("positive reference", c == 1 || c == 3, pos_ref_ext);
            chk1("negative reference", c == 2 || c == 3, neg_ref_ext);
        end
        wr(a_ctl, 16'h0000);
        for (int i = 0; i < 3; i++)
        begin
            wr(a_clk, {3'b000, 5'(sp_t[i]), 8'(dv_t[i])});
            run_seq;
            chk_in("sample cycles", sp_t[i] * (dv_t[i] + 1), dv_t[i] + 1, ns_m);
            chk_in("convert cycles", int'(adc_seq_pkg::conv_periods) * (dv_t[i] + 1), dv_t[i] + 1, nc_m);
        end
        rc_on <= 1'b1;
        wr(a_clk, 16'h82ff);
        run_seq;
        chk_in("rc convert cycles", int'(adc_seq_pkg::conv_periods) * 6, 6, nc_m);
        rc_on <= 1'b0;
        wr(a_clk, 16'h0101);
        wr(adc_seq_pkg::irq_en_off, 16'h0001);
        for (int r = 0; r < 2; r++)
        begin
            wr(a_ctl, {10'h000, 4'(rate_t[r]), 2'b00});
            wr(adc_seq_pkg::irq_clr_off, 16'h0003);
            for (int k = 0; k <= rate_t[r]; k++)
            begin
                run_seq;
                chk("result address", 16'(k), {12'h000, ra_m});
                chk1("interrupt", k == rate_t[r], irq);
            end
        end
        rd_chk("event status", adc_seq_pkg::irq_sts_off, 16'h0001, 16'h0001);
        wr(adc_seq_pkg::irq_en_off, 16'h0000);
        @(posedge ref_clk);
        chk1("masked interrupt", 1'b0, irq);
        wr(adc_seq_pkg::irq_en_off, 16'h0001);
        @(posedge ref_clk);
        chk1("unmasked interrupt", 1'b1, irq);
        wr(adc_seq_pkg::irq_clr_off, 16'h0001);
        @(posedge ref_clk);
        chk1("cleared interrupt", 1'b0, irq);
        rd_chk("cleared status", adc_seq_pkg::irq_sts_off, 16'h0003, 16'h0000);
        wr(a_ctl, 16'h0002);
        rd_chk("fill flag start", a_ctl, 16'h0080, 16'h0000);
        for (int k = 0; k < 3; k++)
        begin
            run_seq;
            chk("split address", (k % 2 == 1) ? 16'h0008 : 16'h0000, {12'h000, ra_m});
            rd_chk("fill flag", a_ctl, 16'h0080, (k % 2 == 0) ? 16'h0080 : 16'h0000);
        end
        rd_chk("half event", adc_seq_pkg::irq_sts_off, 16'h0002, 16'h0002);
        wr(a_chs, 16'h8703);
        wr(a_ctl, 16'h0001);
        for (int k = 0; k < 3; k++)
        begin
            run_seq;
            chk("alternate positive", (k == 1) ? 16'h0007 : 16'h0003, {11'h000, pin_m});
            chk1("alternate negative", k == 1, neg_m);
        end
        scan_list <= 18'h00024;
        wr(a_ctl, 16'h0400);
        for (int k = 0; k < 3; k++)
        begin
            run_seq;
            v[k] = pin_m;
        end
        chk1("scan member", v[0] == 5'h02 || v[0] == 5'h05, 1'b1);
        chk("scan step", (v[0] == 5'h02) ? 16'h0005 : 16'h0002, {11'h000, v[1]});
        chk("scan wrap", {11'h000, v[0]}, {11'h000, v[2]});
        wr(a_ctl, 16'h0000);
        run_seq;
        chk("fixed positive", 16'h0003, {11'h000, pin_m});
        tally_and_finish;
    end
endmodule
`default_nettype wire
